// *** pca_pkg.sv ***
package pca_pkg;
   localparam int NPER = 8;
   localparam int NCPU = 3;
   localparam int NCORE = 2;
   localparam int IDXW = 3;
   localparam int DW = 4;
   localparam int NSRC = 6;
   localparam int SRCW = 3;
   localparam int DIVW = 4;
   localparam int OPW = 3;
   // Kinds of configuration write.
   localparam logic [1:0] KIND_PERIPH = 2'h0;
   localparam logic [1:0] KIND_ISO = 2'h1;
   localparam logic [1:0] KIND_XBAR = 2'h2;
   localparam logic [1:0] KIND_MEM = 2'h3;
   // Field positions inside cfg_data.
   localparam int F_ALLOC = 0;
   localparam int F_KEEP = 1;
   localparam int F_AUTO = 2;
   localparam int F_FILT = 0;
   localparam int F_SEM = 1;
   localparam int F_OWN = 2;
   localparam int F_MEMSH = 0;
   // System power states.
   localparam logic [2:0] SYS_RUN = 3'h0;
   localparam logic [2:0] SYS_STOP1 = 3'h1;
   localparam logic [2:0] SYS_STOP2 = 3'h2;
   localparam logic [2:0] SYS_LP_STOP1 = 3'h3;
   localparam logic [2:0] SYS_LP_STOP2 = 3'h4;
   localparam logic [2:0] SYS_LOW_VOLTAGE_STOP_ONE = 3'h5;
   localparam logic [2:0] SYS_LOW_VOLTAGE_STOP_TWO = 3'h6;
   localparam logic [2:0] SYS_FIRST_STANDBY = 3'h7;
   // Kernel clock sources.
   localparam logic [2:0] SRC_HSI = 3'h0;
   localparam logic [2:0] SRC_MSI = 3'h1;
   localparam logic [2:0] SRC_HSE = 3'h2;
   localparam logic [2:0] SRC_LSE = 3'h3;
   localparam logic [2:0] SRC_LSI = 3'h4;
   localparam logic [2:0] SRC_PLL = 3'h5;
   // Half-period of each source in ref_clk cycles, nibble per source, HSI lowest.
   localparam logic [NSRC*DIVW-1:0] SRC_DIV = 24'h18_8121;
   // Peripheral slots.
   localparam int P_WDG_A = 0;
   localparam int P_WDG_B = 1;
   localparam int P_WDG_C = 2;
   localparam int P_WDG_D = 3;
   localparam int P_PWR_MAIN = 4;
   localparam int P_PWR_AON = 5;
   localparam int P_MEMIF = 6;
   localparam int P_UART = 7;
   // Processors allowed to allocate each slot, one byte per processor, primary lowest.
   localparam logic [NCPU*NPER-1:0] ALLOW_MASK = 24'hF0_FCF3;
   // Slots held by primary and secondary processors at all times.
   localparam logic [NPER-1:0] FIXED_MASK = 8'h30;
   localparam logic [NPER-1:0] SHARE_MASK = 8'h10;
   localparam logic [NPER-1:0] AON_MASK = 8'hA0;
   localparam logic [NPER-1:0] KREQ_MASK = 8'h80;
   // Reset contents.
   localparam logic [NPER-1:0] RST_FILT = 8'h00;
   localparam logic [NPER-1:0] RST_SEM = 8'h00;
   localparam logic [2*NPER-1:0] RST_OWN = 16'h0000;
   localparam logic [SRCW*NPER-1:0] RST_SRC = 24'h00_0000;
   localparam logic RST_MEMSH = 1'b0;
   // User commands of the processor end.
   localparam logic [2:0] OP_PERIPH = 3'h0;
   localparam logic [2:0] OP_ISO = 3'h1;
   localparam logic [2:0] OP_XBAR = 3'h2;
   localparam logic [2:0] OP_MEM = 3'h3;
   localparam logic [2:0] OP_DEDICATE = 3'h4;
   localparam logic [2:0] OP_SHARE = 3'h5;
   typedef enum logic [1:0] {CPU_RUN, CPU_SLEEP, CPU_STOP} pca_cpu_state_e;
endpackage : pca_pkg

// *** pca_if.sv ***
`timescale 1ns/100ps
interface pca_if;
   import pca_pkg::*;
   logic cfg_valid;
   logic [1:0] cfg_kind;
   logic [1:0] cfg_cpu;
   logic cfg_secure;
   logic [IDXW-1:0] cfg_idx;
   logic [DW-1:0] cfg_data;
   logic cfg_ack;
   logic cfg_err;
   logic [NCORE-1:0] primary_core_idle;
   logic [1:0] stop_request_field;
   logic secondary_idle;
   logic secondary_deep;
   logic third_idle;
   logic third_deep;
   logic [2:0] sys_state;
   logic [NPER-1:0] kernel_clock_request;
   logic [NPER-1:0] bus_clock_request;
   logic [NPER-1:0] bus_clk;
   logic [NPER-1:0] ker_clk;
   logic [NPER*NCPU-1:0] alloc_status;
   modport ctrl (
      input cfg_valid, cfg_kind, cfg_cpu, cfg_secure, cfg_idx, cfg_data,
      input primary_core_idle, stop_request_field, secondary_idle, secondary_deep,
      input third_idle, third_deep, sys_state, kernel_clock_request, bus_clock_request,
      output cfg_ack, cfg_err, bus_clk, ker_clk, alloc_status
   );
   modport agent (
      output cfg_valid, cfg_kind, cfg_cpu, cfg_secure, cfg_idx, cfg_data,
      output primary_core_idle, stop_request_field, secondary_idle, secondary_deep,
      output third_idle, third_deep, sys_state, kernel_clock_request, bus_clock_request,
      input cfg_ack, cfg_err, bus_clk, ker_clk, alloc_status
   );
endinterface : pca_if

// *** pca_ctrl.sv ***
`timescale 1ns/100ps
//Contract
// - Alloc bit set allocates, clear releases.
// - Sleep-keep holds clocks during owner sleep.
// - Autonomous bit keeps always-on peripherals clocked deep.
// - Six contexts: three processors, secure/non-secure.
// - Reset context assignment, runtime change allowed.
// - Software sets semaphore-shared for dual use.
// - Single-access: only designated processor allocates.
// - Release single-access before reallocation or reconfiguration.
// - Dedicate: filter one, semaphore zero, owner.
// - Memory interface shareable only with share bit.
// - Watchdogs split; power/clock controllers both processors.
// - Only main-domain power controller shareable.
// - Gating follows owner state automatically.
// - Enables from bits, states, requests, source.
// - Primary state: core idles plus stop field.
// - Other processors follow own low-power setting.
// - System state qualifies autonomous requests.
// - Kernel clock rate from crossbar source.
// - Bus clock enable conditions per owner state.
// - Kernel clock enable conditions per owner state.
// - Only serial peripherals raise kernel requests.
module pca_ctrl (
   input wire logic ref_clk,
   input wire logic nrst,
   pca_if.ctrl link
);
   import pca_pkg::*;

   function automatic pca_cpu_state_e lp_state(input logic idle, input logic deep);
      lp_state = !idle ? CPU_RUN : (deep ? CPU_STOP : CPU_SLEEP);
   endfunction : lp_state

   function automatic logic is_fast(input logic [SRCW-1:0] s);
      is_fast = (s == SRC_HSI) || (s == SRC_MSI) || (s == SRC_HSE);
   endfunction : is_fast

   function automatic logic is_low(input logic [SRCW-1:0] s);
      is_low = (s == SRC_LSE) || (s == SRC_LSI);
   endfunction : is_low

   logic [NCPU-1:0] alloc_ff [NPER];
   logic [NPER-1:0] keep_ff;
   logic [NPER-1:0] auto_ff;
   logic [NPER-1:0] filt_ff;
   logic [NPER-1:0] sem_ff;
   logic [1:0] own_ff [NPER];
   logic [SRCW-1:0] src_ff [NPER];
   logic mem_share_ff;
   logic ack_ff;
   logic err_ff;
   logic [NPER-1:0] bus_clk_ff;
   logic [NPER-1:0] ker_clk_ff;
   logic [NSRC-1:0] tick_ff;
   pca_cpu_state_e st [NCPU];
   logic deep_sys;
   logic refuse;
   logic shared_now;
   logic held_other;
   logic [NCPU-1:0] cpu_bit;

   // The primary processor is stopped only once every core idles and a stop is requested.
   always_comb begin
      if (!(&link.primary_core_idle)) begin
         st[0] = CPU_RUN;
      end else if (link.stop_request_field != 2'h0) begin
         st[0] = CPU_STOP;
      end else begin
         st[0] = CPU_SLEEP;
      end
      st[1] = lp_state(link.secondary_idle, link.secondary_deep);
      st[2] = lp_state(link.third_idle, link.third_deep);
   end

   assign deep_sys = (link.sys_state == SYS_LOW_VOLTAGE_STOP_ONE) || (link.sys_state == SYS_LOW_VOLTAGE_STOP_TWO) ||
      (link.sys_state == SYS_FIRST_STANDBY);

   always_comb begin
      cpu_bit = NCPU'(1) << link.cfg_cpu;
      held_other = |(alloc_ff[link.cfg_idx] & ~cpu_bit);
      shared_now = (SHARE_MASK[link.cfg_idx] || (int'(link.cfg_idx) == P_MEMIF && mem_share_ff)) &&
         sem_ff[link.cfg_idx];
      refuse = 1'b0;
      case (link.cfg_kind)
         KIND_PERIPH: begin
            if (link.cfg_data[F_ALLOC] && !alloc_ff[link.cfg_idx][link.cfg_cpu]) begin
               if (!ALLOW_MASK[int'(link.cfg_cpu) * NPER + int'(link.cfg_idx)]) begin
                  refuse = 1'b1;
               end else if (!shared_now && filt_ff[link.cfg_idx] && own_ff[link.cfg_idx] != link.cfg_cpu) begin
                  refuse = 1'b1;
               end else if (!shared_now && held_other) begin
                  refuse = 1'b1;
               end
            end
         end
         KIND_ISO: begin
            // Isolation is owned by the secure contexts only.
            refuse = !link.cfg_secure || (|alloc_ff[link.cfg_idx] && !shared_now);
         end
         default: begin
            refuse = 1'b0;
         end
      endcase
      if (link.cfg_cpu >= 2'(NCPU)) begin
         refuse = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         ack_ff <= link.cfg_valid;
         err_ff <= link.cfg_valid && refuse;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int p = 0; p < NPER; p++) begin
            alloc_ff[p] <= '0;
         end
         keep_ff <= '0;
         auto_ff <= '0;
      end else if (link.cfg_valid && link.cfg_kind == KIND_PERIPH && link.cfg_cpu < 2'(NCPU)) begin
         if (!refuse) begin
            alloc_ff[link.cfg_idx][link.cfg_cpu] <= link.cfg_data[F_ALLOC];
         end
         keep_ff[link.cfg_idx] <= link.cfg_data[F_KEEP];
         auto_ff[link.cfg_idx] <= link.cfg_data[F_AUTO] && AON_MASK[link.cfg_idx];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         filt_ff <= RST_FILT;
         sem_ff <= RST_SEM;
         for (int p = 0; p < NPER; p++) begin
            own_ff[p] <= RST_OWN[2*p +: 2];
         end
         mem_share_ff <= RST_MEMSH;
      end else if (link.cfg_valid && !refuse) begin
         if (link.cfg_kind == KIND_ISO) begin
            filt_ff[link.cfg_idx] <= link.cfg_data[F_FILT];
            sem_ff[link.cfg_idx] <= link.cfg_data[F_SEM];
            own_ff[link.cfg_idx] <= link.cfg_data[F_OWN +: 2];
         end else if (link.cfg_kind == KIND_MEM) begin
            mem_share_ff <= link.cfg_data[F_MEMSH];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int p = 0; p < NPER; p++) begin
            src_ff[p] <= RST_SRC[SRCW*p +: SRCW];
         end
      end else if (link.cfg_valid && link.cfg_kind == KIND_XBAR && !refuse && link.cfg_data[SRCW-1:0] < 3'(NSRC)) begin
         src_ff[link.cfg_idx] <= link.cfg_data[SRCW-1:0];
      end
   end

   genvar s;
   generate
      for (s = 0; s < NSRC; s++) begin : g_src
         logic [DIVW-1:0] cnt_ff;
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               cnt_ff <= '0;
               tick_ff[s] <= 1'b0;
            end else if (cnt_ff >= SRC_DIV[s*DIVW +: DIVW] - 4'h1) begin
               cnt_ff <= '0;
               tick_ff[s] <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff + 4'h1;
               tick_ff[s] <= 1'b0;
            end
         end
      end
   endgenerate

   genvar p;
   generate
      for (p = 0; p < NPER; p++) begin : g_per
         logic be;
         logic ke;
         logic kreq;
         logic amen;
         logic [SRCW-1:0] sel_ff;
         assign kreq = link.kernel_clock_request[p] && KREQ_MASK[p];
         assign amen = auto_ff[p] && AON_MASK[p];
         always_comb begin
            be = 1'b0;
            ke = 1'b0;
            for (int c = 0; c < NCPU; c++) begin
               if (alloc_ff[p][c] || (FIXED_MASK[p] && c < 2)) begin
                  case (st[c])
                     CPU_RUN: begin
                        be = 1'b1;
                        ke = 1'b1;
                     end
                     CPU_SLEEP: begin
                        be = be || keep_ff[p];
                        ke = ke || keep_ff[p];
                     end
                     CPU_STOP: begin
                        // Deep system states let only autonomous peripherals' bus clocks through; the kernel enable ignores the system state.
                        be = be || (keep_ff[p] && link.bus_clock_request[p] && (!deep_sys || amen));
                        ke = ke || (keep_ff[p] && ((kreq && is_fast(src_ff[p])) || is_low(src_ff[p]) ||
                           (amen && kreq && (is_low(src_ff[p]) || src_ff[p] == SRC_MSI))));
                     end
                     default: begin
                        be = be;
                     end
                  endcase
               end
            end
         end
         // Enables are only taken while the output is low, so high phases are never cut short.
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               bus_clk_ff[p] <= 1'b0;
            end else begin
               bus_clk_ff[p] <= !bus_clk_ff[p] && be;
            end
         end
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               ker_clk_ff[p] <= 1'b0;
               sel_ff <= '0;
            end else if (!ker_clk_ff[p] && sel_ff != src_ff[p]) begin
               sel_ff <= src_ff[p];
            end else if (tick_ff[sel_ff]) begin
               ker_clk_ff[p] <= !ker_clk_ff[p] && ke;
            end
         end
         assign link.alloc_status[p*NCPU +: NCPU] = alloc_ff[p];
      end
   endgenerate

   assign link.cfg_ack = ack_ff;
   assign link.cfg_err = err_ff;
   assign link.bus_clk = bus_clk_ff;
   assign link.ker_clk = ker_clk_ff;
endmodule : pca_ctrl

// *** pca_agent.sv ***
`timescale 1ns/100ps
module pca_agent (
   input wire logic ref_clk,
   input wire logic nrst,
   pca_if.agent link,
   input wire logic cmd_valid,
   input wire logic [pca_pkg::OPW-1:0] cmd_op,
   input wire logic [1:0] cmd_cpu,
   input wire logic cmd_secure,
   input wire logic [pca_pkg::IDXW-1:0] cmd_idx,
   input wire logic [pca_pkg::DW-1:0] cmd_arg,
   output logic cmd_ready,
   output logic cmd_done,
   output logic cmd_err,
   input wire logic [pca_pkg::NCORE-1:0] core_idle,
   input wire logic [1:0] stop_req,
   input wire logic sec_idle,
   input wire logic sec_deep,
   input wire logic thd_idle,
   input wire logic thd_deep,
   input wire logic [2:0] sys_state,
   input wire logic [pca_pkg::NPER-1:0] ker_req,
   input wire logic [pca_pkg::NPER-1:0] bus_req,
   output logic [pca_pkg::NPER-1:0] periph_bus_clk,
   output logic [pca_pkg::NPER-1:0] periph_ker_clk
);
   import pca_pkg::*;
   typedef enum logic [1:0] {AG_IDLE, AG_SEND, AG_WAIT} pca_ag_e;
   pca_ag_e st_ff;
   logic valid_ff;
   logic [1:0] kind_ff;
   logic [1:0] cpu_ff;
   logic sec_ff;
   logic [IDXW-1:0] idx_ff;
   logic [DW-1:0] data_ff;
   logic ready_ff;
   logic done_ff;
   logic err_ff;
   logic [NCORE+13-1:0] state_ff;
   logic [2*NPER-1:0] req_ff;
   logic [2*NPER-1:0] clk_ff;
   logic [1:0] nxt_kind;
   logic [DW-1:0] nxt_data;

   always_comb begin
      nxt_kind = cmd_op[1:0];
      nxt_data = cmd_arg;
      case (cmd_op)
         OP_DEDICATE: begin
            nxt_kind = KIND_ISO;
            nxt_data = {cmd_cpu, 1'b0, 1'b1};
         end
         OP_SHARE: begin
            nxt_kind = KIND_ISO;
            nxt_data = {cmd_arg[3:2], 1'b1, 1'b1};
         end
         default: begin
            nxt_kind = cmd_op[1:0];
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= AG_IDLE;
         valid_ff <= 1'b0;
         kind_ff <= '0;
         cpu_ff <= '0;
         sec_ff <= 1'b0;
         idx_ff <= '0;
         data_ff <= '0;
         ready_ff <= 1'b0;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         case (st_ff)
            AG_IDLE: begin
               ready_ff <= 1'b1;
               if (cmd_valid && ready_ff) begin
                  ready_ff <= 1'b0;
                  valid_ff <= 1'b1;
                  kind_ff <= nxt_kind;
                  cpu_ff <= cmd_cpu;
                  sec_ff <= cmd_secure;
                  idx_ff <= cmd_idx;
                  data_ff <= nxt_data;
                  st_ff <= AG_SEND;
               end
            end
            AG_SEND: begin
               valid_ff <= 1'b0;
               st_ff <= AG_WAIT;
            end
            AG_WAIT: begin
               if (link.cfg_ack) begin
                  done_ff <= 1'b1;
                  err_ff <= link.cfg_err;
                  st_ff <= AG_IDLE;
               end
            end
            default: begin
               st_ff <= AG_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= '0;
         req_ff <= '0;
         clk_ff <= '0;
      end else begin
         state_ff <= {core_idle, stop_req, sec_idle, sec_deep, thd_idle, thd_deep, sys_state, 4'h0};
         req_ff <= {ker_req, bus_req};
         clk_ff <= {link.ker_clk, link.bus_clk};
      end
   end

   assign link.cfg_valid = valid_ff;
   assign link.cfg_kind = kind_ff;
   assign link.cfg_cpu = cpu_ff;
   assign link.cfg_secure = sec_ff;
   assign link.cfg_idx = idx_ff;
   assign link.cfg_data = data_ff;
   assign link.primary_core_idle = state_ff[NCORE+12:13];
   assign link.stop_request_field = state_ff[12:11];
   assign link.secondary_idle = state_ff[10];
   assign link.secondary_deep = state_ff[9];
   assign link.third_idle = state_ff[8];
   assign link.third_deep = state_ff[7];
   assign link.sys_state = state_ff[6:4];
   assign link.kernel_clock_request = req_ff[2*NPER-1:NPER];
   assign link.bus_clock_request = req_ff[NPER-1:0];
   assign cmd_ready = ready_ff;
   assign cmd_done = done_ff;
   assign cmd_err = err_ff;
   assign periph_ker_clk = clk_ff[2*NPER-1:NPER];
   assign periph_bus_clk = clk_ff[NPER-1:0];
endmodule : pca_agent

// *** pca_chk.sv ***
`timescale 1ns/100ps
module pca_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cfg_valid,
   input wire logic [1:0] cfg_kind,
   input wire logic [1:0] cfg_cpu,
   input wire logic cfg_secure,
   input wire logic [pca_pkg::IDXW-1:0] cfg_idx,
   input wire logic [pca_pkg::DW-1:0] cfg_data,
   input wire logic cfg_ack,
   input wire logic cfg_err,
   input wire logic [pca_pkg::NCORE-1:0] primary_core_idle,
   input wire logic [1:0] stop_request_field,
   input wire logic secondary_idle,
   input wire logic [pca_pkg::NPER-1:0] bus_clock_request,
   input wire logic [pca_pkg::NPER-1:0] bus_clk,
   input wire logic [pca_pkg::NPER*pca_pkg::NCPU-1:0] alloc_status
);
   import pca_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Every write is answered exactly one cycle later, never spontaneously.
   cfg_ack_timing_a: assert property (cfg_ack == $past(cfg_valid)) else $error("ack not one cycle after write");
   alloc_barred_a: assert property (cfg_valid && cfg_kind == KIND_PERIPH && cfg_data[F_ALLOC] && cfg_cpu != 2'h3
      && !ALLOW_MASK[cfg_cpu * NPER + cfg_idx] |=> cfg_err && !alloc_status[$past(cfg_idx) * NCPU + $past(cfg_cpu)])
      else $error("barred allocation accepted");
   release_ok_a: assert property (cfg_valid && cfg_kind == KIND_PERIPH && !cfg_data[F_ALLOC] && cfg_cpu != 2'h3
      |=> !cfg_err && !alloc_status[$past(cfg_idx) * NCPU + $past(cfg_cpu)]) else $error("release failed");
   grant_or_err_a: assert property (cfg_valid && cfg_kind == KIND_PERIPH && cfg_data[F_ALLOC] && cfg_cpu != 2'h3
      |=> cfg_err || alloc_status[$past(cfg_idx) * NCPU + $past(cfg_cpu)]) else $error("silent allocation loss");
   ctx_refuse_a: assert property (cfg_valid && (cfg_cpu == 2'h3 || (cfg_kind == KIND_ISO && !cfg_secure))
      |=> cfg_err) else $error("bad context accepted");
   // A high phase longer than one cycle would be a stretched pulse.
   bus_glitch_a: assert property ((bus_clk & $past(bus_clk)) == '0) else $error("bus clock high twice");
   bus_run_a: assert property ((alloc_status[21] && primary_core_idle != 2'h3) [*3]
      |-> bus_clk[7] != $past(bus_clk[7])) else $error("bus clock idle for running owner");
   bus_stop_a: assert property ((alloc_status[23:21] == 3'h1 && primary_core_idle == 2'h3
      && stop_request_field != 2'h0 && !bus_clock_request[7]) [*3] |-> !bus_clk[7]) else $error("stop clocked");
   free_slot_a: assert property ((alloc_status[20:18] == 3'h0) [*3] |-> !bus_clk[6])
      else $error("unallocated slot clocked");
   sec_run_a: assert property ((alloc_status[10] && !secondary_idle) [*3] |-> bus_clk[3] != $past(bus_clk[3]))
      else $error("secondary running but slot idle");
endmodule : pca_chk

// *** peripheral_clock_allocation_tb.sv ***
`timescale 1ns/100ps
module peripheral_clock_allocation_tb;
   import pca_pkg::*;
   logic ref_clk;
   logic nrst;
   logic cmd_valid;
   logic [OPW-1:0] cmd_op;
   logic [1:0] cmd_cpu;
   logic cmd_secure;
   logic [IDXW-1:0] cmd_idx;
   logic [DW-1:0] cmd_arg;
   logic cmd_ready;
   logic cmd_done;
   logic cmd_err;
   logic [NCORE-1:0] core_idle;
   logic [1:0] stop_req;
   logic sec_idle;
   logic sec_deep;
   logic thd_idle;
   logic thd_deep;
   logic [2:0] sys_state;
   logic [NPER-1:0] ker_req;
   logic [NPER-1:0] bus_req;
   logic [NPER-1:0] pbus;
   logic [NPER-1:0] pker;
   logic keep;
   logic auto_en;
   logic [2:0] src;
   logic [31:0] r;
   int error_cnt;
   int checks;
   int cyc;
   int nb;
   int nk;
   int o;
   integer seed;
   pca_if link_if();
   pca_ctrl i_pca_ctrl (.ref_clk(ref_clk), .nrst(nrst), .link(link_if));
   pca_agent i_pca_agent (.ref_clk(ref_clk), .nrst(nrst), .link(link_if), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_cpu(cmd_cpu), .cmd_secure(cmd_secure), .cmd_idx(cmd_idx), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
      .cmd_done(cmd_done), .cmd_err(cmd_err), .core_idle(core_idle), .stop_req(stop_req), .sec_idle(sec_idle),
      .sec_deep(sec_deep), .thd_idle(thd_idle), .thd_deep(thd_deep), .sys_state(sys_state), .ker_req(ker_req),
      .bus_req(bus_req), .periph_bus_clk(pbus), .periph_ker_clk(pker));
   pca_chk i_pca_chk (.ref_clk(ref_clk), .nrst(nrst), .cfg_valid(link_if.cfg_valid), .cfg_kind(link_if.cfg_kind),
      .cfg_cpu(link_if.cfg_cpu), .cfg_secure(link_if.cfg_secure), .cfg_idx(link_if.cfg_idx),
      .cfg_data(link_if.cfg_data), .cfg_ack(link_if.cfg_ack), .cfg_err(link_if.cfg_err),
      .primary_core_idle(link_if.primary_core_idle), .stop_request_field(link_if.stop_request_field),
      .secondary_idle(link_if.secondary_idle), .bus_clock_request(link_if.bus_clock_request),
      .bus_clk(link_if.bus_clk), .alloc_status(link_if.alloc_status));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic test_done();
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic do_cmd(input logic [2:0] op, input logic [1:0] cpu, input logic sec, input logic [2:0] idx,
         input logic [3:0] arg, input logic exp);
      int n;
      n = 0;
      #1;
      while (cmd_ready !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_cpu <= cpu;
      cmd_secure <= sec;
      cmd_idx <= idx;
      cmd_arg <= arg;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      n = 0;
      while (cmd_done !== 1'b1 && n < 10) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk({cmd_done, cmd_err}, {1'b1, exp});
   endtask : do_cmd

   // The settle time covers a slow kernel clock finishing its high phase before it parks low.
   task automatic measure(input int p);
      logic pb;
      logic pk;
      nb = 0;
      nk = 0;
      repeat (12) @(posedge ref_clk);
      #1;
      pb = pbus[p];
      pk = pker[p];
      repeat (24) begin
         @(posedge ref_clk);
         #1;
         nb += int'(pbus[p] !== pb);
         nk += int'(pker[p] !== pk);
         pb = pbus[p];
         pk = pker[p];
      end
   endtask : measure

   function automatic int own_state(int c);
      if (c == 0) return (core_idle != 2'h3) ? 0 : ((stop_req != 2'h0) ? 2 : 1);
      if (c == 1) return !sec_idle ? 0 : (sec_deep ? 2 : 1);
      return !thd_idle ? 0 : (thd_deep ? 2 : 1);
   endfunction : own_state

   function automatic logic bus_exp(int s);
      if (s < 2) return s == 0 || keep;
      return keep && bus_req[7] && (sys_state < 3'h5 || auto_en);
   endfunction : bus_exp

   function automatic logic ker_ok(int s);
      logic low_src;
      logic en;
      int e;
      low_src = (src == SRC_LSE || src == SRC_LSI);
      e = 24 / int'(SRC_DIV[int'(src) * DIVW +: DIVW]);
      en = s == 0 || (s == 1 && keep) || (s == 2 && keep && ((ker_req[7] && src < SRC_LSE) || low_src
         || (auto_en && ker_req[7] && (low_src || src == SRC_MSI))));
      if (!en) return nk == 0;
      return nk + 1 >= e && nk <= e + 1;
   endfunction : ker_ok

   initial begin
      seed = 32'h568d_3a00;
      {nrst, cmd_valid, cmd_op, cmd_cpu, cmd_secure, cmd_idx, cmd_arg} = '0;
      {core_idle, stop_req, sec_idle, sec_deep, thd_idle, thd_deep, sys_state, ker_req, bus_req} = '0;
      {keep, auto_en, src} = '0;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk(link_if.alloc_status, 24'h00_0000);
      for (int i = 0; i < 8; i++) begin
         o = i % 2;
         do_cmd(OP_PERIPH, 2'(o), 1'b0, 3'(i / 2), 4'h1, (i < 4) != (o == 0));
         chk(link_if.alloc_status[(i / 2) * 3 + o], (i < 4) == (o == 0));
         do_cmd(OP_PERIPH, 2'(o), 1'b0, 3'(i / 2), 4'h0, 1'b0);
      end
      @(posedge ref_clk);
      core_idle <= 2'h3;
      stop_req <= 2'h1;
      measure(4);
      chk(nb, 24);
      $display("test watchdog done");
      do_cmd(OP_PERIPH, 2'h3, 1'b1, 3'h7, 4'h1, 1'b1);
      do_cmd(OP_ISO, 2'h0, 1'b0, 3'h7, 4'h0, 1'b1);
      do_cmd(OP_ISO, 2'h0, 1'b1, 3'h7, 4'h0, 1'b0);
      do_cmd(OP_DEDICATE, 2'h1, 1'b1, 3'h7, 4'h0, 1'b0);
      do_cmd(OP_PERIPH, 2'h0, 1'b0, 3'h7, 4'h1, 1'b1);
      do_cmd(OP_PERIPH, 2'h1, 1'b0, 3'h7, 4'h1, 1'b0);
      do_cmd(OP_ISO, 2'h0, 1'b1, 3'h7, 4'h0, 1'b1);
      do_cmd(OP_PERIPH, 2'h1, 1'b0, 3'h7, 4'h0, 1'b0);
      do_cmd(OP_ISO, 2'h0, 1'b1, 3'h7, 4'h0, 1'b0);
      do_cmd(OP_PERIPH, 2'h0, 1'b0, 3'h7, 4'h1, 1'b0);
      do_cmd(OP_PERIPH, 2'h0, 1'b0, 3'h7, 4'h0, 1'b0);
      $display("test isolation done");
      do_cmd(OP_SHARE, 2'h0, 1'b1, 3'h4, 4'h0, 1'b0);
      do_cmd(OP_ISO, 2'h0, 1'b1, 3'h5, 4'h2, 1'b0);
      do_cmd(OP_ISO, 2'h0, 1'b1, 3'h6, 4'h2, 1'b0);
      do_cmd(OP_PERIPH, 2'h0, 1'b0, 3'h4, 4'h1, 1'b0);
      do_cmd(OP_PERIPH, 2'h1, 1'b0, 3'h4, 4'h1, 1'b0);
      do_cmd(OP_PERIPH, 2'h0, 1'b0, 3'h5, 4'h1, 1'b0);
      do_cmd(OP_PERIPH, 2'h1, 1'b0, 3'h5, 4'h1, 1'b1);
      do_cmd(OP_PERIPH, 2'h0, 1'b0, 3'h6, 4'h1, 1'b0);
      do_cmd(OP_PERIPH, 2'h1, 1'b0, 3'h6, 4'h1, 1'b1);
      do_cmd(OP_MEM, 2'h0, 1'b1, 3'h6, 4'h1, 1'b0);
      do_cmd(OP_PERIPH, 2'h1, 1'b0, 3'h6, 4'h1, 1'b0);
      for (int i = 0; i < 6; i++) begin
         do_cmd(OP_PERIPH, 2'(i % 2), 1'b0, 3'(4 + i / 2), 4'h0, 1'b0);
      end
      $display("test sharing done");
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         o = int'(r[3:2]) % 3;
         keep = r[0] | (i < 6);
         auto_en = r[1];
         src = 3'(r[6:4] % 3'h6);
         do_cmd(OP_PERIPH, 2'(o), 1'b0, 3'h7, {1'b0, auto_en, keep, 1'b1}, 1'b0);
         do_cmd(OP_XBAR, 2'(o), 1'b0, 3'h7, {1'b0, src}, 1'b0);
         @(posedge ref_clk);
         core_idle <= r[9:8];
         stop_req <= r[11:10];
         sec_idle <= r[12];
         sec_deep <= r[13];
         thd_idle <= r[14];
         thd_deep <= r[15];
         sys_state <= r[18:16];
         ker_req <= r[26:19];
         bus_req <= {r[27], r[7:1]};
         measure(7);
         chk(nb, bus_exp(own_state(o)) ? 24 : 0);
         chk(ker_ok(own_state(o)), 1'b1);
         do_cmd(OP_PERIPH, 2'(o), 1'b0, 3'h7, 4'h0, 1'b0);
      end
      $display("test gating done");
      test_done();
   end
endmodule : peripheral_clock_allocation_tb
